// ==== sfd_delay_line.v ====
// streaming fixed delay line with an AXI4-Lite status and control slave
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "sfd_consts.vh"
// ----------------------------------------------------------------------------
// Functional notes
// - every beat is delayed by a build-time count N of at most 16 cycles
// - every input beat is taken and leaves unchanged exactly N cycles later
// - each input valid change reappears on output valid exactly N cycles later
// - reset is sampled on the clock (with N zero it gates the outputs directly); all stream outputs read zero while it is low
// - after release outputs stay zero N cycles, then carry inputs from N earlier
// - no ready exists; the sink must take every output beat
// - delay legal from 0 to 16, default 1; zero means plain pass-through
// - data width configurable from 1 to 512 bits, default 8
// - symbol size configurable from 1 to 512 bits, default 8, same both sides
// - packet option adds start, end and empty through the same delay
// - channel option delays a channel field of 0 to 8 bits, up to 255 channels
// - error option delays an error field of 0 to 31 bits; zero width means none
// ----------------------------------------------------------------------------
module sfd_delay_line #(
	parameter DELAY = `SFD_DEF_DELAY,
	parameter DATA_W = `SFD_DEF_DATA_W,
	parameter SYM_W = `SFD_DEF_SYM_W,
	parameter USE_PACKETS = 0,
	parameter USE_CHANNEL = 0,
	parameter CHAN_W = `SFD_DEF_CHAN_W,
	parameter MAX_CHAN = `SFD_DEF_MAX_CHAN,
	parameter USE_ERROR = 0,
	parameter ERR_W = `SFD_DEF_ERR_W,
	// derived widths, kept here so the port list can use them; never override
	parameter SYMS = (DATA_W + SYM_W - 1) / SYM_W,
	parameter EMPTY_W = (SYMS > 256) ? 9 : (SYMS > 128) ? 8 : (SYMS > 64) ? 7 : (SYMS > 32) ? 6 :
		(SYMS > 16) ? 5 : (SYMS > 8) ? 4 : (SYMS > 4) ? 3 : (SYMS > 2) ? 2 : 1,
	parameter CHAN_P = (CHAN_W > 0) ? CHAN_W : 1,
	parameter ERR_P = (ERR_W > 0) ? ERR_W : 1
) (
	input wire aclk,
	input wire aresetn,
	input wire in_valid,
	input wire [DATA_W-1:0] in_data,
	input wire in_startofpacket,
	input wire in_endofpacket,
	input wire [EMPTY_W-1:0] in_empty,
	input wire [CHAN_P-1:0] in_channel,
	input wire [ERR_P-1:0] in_error,
	output wire out_valid,
	output wire [DATA_W-1:0] out_data,
	output wire out_startofpacket,
	output wire out_endofpacket,
	output wire [EMPTY_W-1:0] out_empty,
	output wire [CHAN_P-1:0] out_channel,
	output wire [ERR_P-1:0] out_error,
	input wire [`SFD_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`SFD_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready
);
	// zero-width fields are carried as one unused bit, held at zero
	localparam TW = 1 + DATA_W + 2 + EMPTY_W + CHAN_P + ERR_P;
	// an oversized delay is clamped rather than building a longer pipe
	localparam ND = (DELAY > `SFD_MAX_DELAY) ? `SFD_MAX_DELAY : (DELAY > 0) ? DELAY : 1;
	localparam [4:0] DELAY_5 = DELAY;

	// ------------------------------------------------------------------------
	// delay pipeline
	// ------------------------------------------------------------------------
	wire pkt_on = (USE_PACKETS != 0);
	wire chan_on = (USE_CHANNEL != 0) && (CHAN_W > 0);
	wire err_on = (USE_ERROR != 0) && (ERR_W > 0);
	wire [TW-1:0] beat_in;
	wire [TW-1:0] beat_out;

	// field positions inside one pipeline word, valid on top
	localparam ERR_LO = 0;
	localparam CHAN_LO = ERR_LO + ERR_P;
	localparam EMPTY_LO = CHAN_LO + CHAN_P;
	localparam EOP_BIT = EMPTY_LO + EMPTY_W;
	localparam SOP_BIT = EOP_BIT + 1;
	localparam DATA_LO = SOP_BIT + 1;
	localparam VALID_BIT = DATA_LO + DATA_W;

	// disabled options enter as zero so their outputs stay zero
	assign beat_in[VALID_BIT] = in_valid;
	assign beat_in[DATA_LO +: DATA_W] = in_data;
	assign beat_in[SOP_BIT] = in_startofpacket & pkt_on;
	assign beat_in[EOP_BIT] = in_endofpacket & pkt_on;
	assign beat_in[EMPTY_LO +: EMPTY_W] = in_empty & {EMPTY_W{pkt_on}};
	assign beat_in[CHAN_LO +: CHAN_P] = in_channel & {CHAN_P{chan_on}};
	assign beat_in[ERR_LO +: ERR_P] = in_error & {ERR_P{err_on}};

	genvar g;
	generate
		if (DELAY == 0) begin : g_pass
			// no register at all: the value is the input, forced to zero in reset
			assign beat_out = aresetn ? beat_in : {TW{1'b0}};
		end else begin : g_pipe
			reg [TW-1:0] stage_q [0:ND-1];
			for (g = 0; g < ND; g = g + 1) begin : g_stage
				always @(posedge aclk) begin
					if (!aresetn) begin
						stage_q[g] <= {TW{1'b0}};
					end else begin
						stage_q[g] <= (g == 0) ? beat_in : stage_q[(g == 0) ? 0 : g - 1];
					end
				end
			end
			assign beat_out = stage_q[ND-1];
		end
	endgenerate

	// no ready in either direction, so nothing can stall the pipe
	assign out_valid = beat_out[VALID_BIT];
	assign out_data = beat_out[DATA_LO +: DATA_W];
	assign out_startofpacket = beat_out[SOP_BIT];
	assign out_endofpacket = beat_out[EOP_BIT];
	assign out_empty = beat_out[EMPTY_LO +: EMPTY_W];
	assign out_channel = beat_out[CHAN_LO +: CHAN_P];
	assign out_error = beat_out[ERR_LO +: ERR_P];

	// ------------------------------------------------------------------------
	// control and beat counter
	// ------------------------------------------------------------------------
	reg cnt_en_q;
	reg [31:0] beats_q;
	reg clr_req;
	reg ctrl_we;
	reg ctrl_en_d;

	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_en_q <= `SFD_CTRL_RST;
			beats_q <= `SFD_BEATS_RST;
		end else begin
			if (ctrl_we) begin
				cnt_en_q <= ctrl_en_d;
			end
			// a beat leaving in the clear cycle is kept: it counts as the first
			if (clr_req) begin
				beats_q <= {31'h0000_0000, out_valid & cnt_en_q};
			end else if (out_valid && cnt_en_q) begin
				beats_q <= beats_q + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------------------
	reg aw_got_q;
	reg w_got_q;
	reg [`SFD_ADDR_W-1:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;
	wire aw_ok = aw_got_q || (s_axi_awvalid && s_axi_awready);
	wire w_ok = w_got_q || (s_axi_wvalid && s_axi_wready);
	wire [`SFD_ADDR_W-1:0] wa = aw_got_q ? awaddr_q : s_axi_awaddr;
	wire [31:0] wd = w_got_q ? wdata_q : s_axi_wdata;
	wire [3:0] ws = w_got_q ? wstrb_q : s_axi_wstrb;
	wire commit = aw_ok && w_ok && !s_axi_bvalid;

	always @* begin
		ctrl_we = commit && (wa == `SFD_OFF_CTRL) && ws[0];
		ctrl_en_d = wd[`SFD_CTRL_CNT_EN];
		clr_req = ctrl_we && wd[`SFD_CTRL_CNT_CLR];
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= {`SFD_ADDR_W{1'b0}};
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SFD_RESP_OKAY;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (commit) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wa == `SFD_OFF_CTRL) ? `SFD_RESP_OKAY : `SFD_RESP_SLVERR;
			end else begin
				if (s_axi_awvalid && s_axi_awready) begin
					aw_got_q <= 1'b1;
					awaddr_q <= s_axi_awaddr;
					s_axi_awready <= 1'b0;
				end
				if (s_axi_wvalid && s_axi_wready) begin
					w_got_q <= 1'b1;
					wdata_q <= s_axi_wdata;
					wstrb_q <= s_axi_wstrb;
					s_axi_wready <= 1'b0;
				end
			end
		end
	end

	// ------------------------------------------------------------------------
	// AXI4-Lite read side through a two-entry buffer
	// ------------------------------------------------------------------------
	reg [33:0] rd_word;
	reg [33:0] head_q;
	reg [33:0] tail_q;
	reg [1:0] fill_q;
	reg [1:0] fill_d;
	reg rvalid_q;
	wire [31:0] cfg_word;
	wire push = s_axi_arvalid && s_axi_arready;

	assign cfg_word[31:11] = 21'h00_0000;
	assign cfg_word[`SFD_CFG_ERR_BIT] = err_on;
	assign cfg_word[`SFD_CFG_CHAN_BIT] = chan_on;
	assign cfg_word[`SFD_CFG_PKT_BIT] = pkt_on;
	assign cfg_word[7:5] = 3'h0;
	assign cfg_word[`SFD_CFG_DELAY_LSB +: 5] = DELAY_5;
	wire pop = s_axi_rvalid && s_axi_rready;

	always @* begin
		rd_word = {`SFD_RESP_SLVERR, 32'h0000_0000};
		case (s_axi_araddr)
			`SFD_OFF_CTRL: rd_word = {`SFD_RESP_OKAY, 31'h0000_0000, cnt_en_q};
			`SFD_OFF_BEATS: rd_word = {`SFD_RESP_OKAY, beats_q};
			`SFD_OFF_CFG: rd_word = {`SFD_RESP_OKAY, cfg_word};
			default: rd_word = {`SFD_RESP_SLVERR, 32'h0000_0000};
		endcase
		fill_d = fill_q + {1'b0, push} - {1'b0, pop};
	end

	// a stalled rready fills the buffer, and its fullness drops arready
	always @(posedge aclk) begin
		if (!aresetn) begin
			head_q <= 34'h0_0000_0000;
			tail_q <= 34'h0_0000_0000;
			fill_q <= 2'h0;
			rvalid_q <= 1'b0;
			s_axi_arready <= 1'b1;
		end else begin
			fill_q <= fill_d;
			// registered copy of the fill test keeps rvalid straight from a flop
			rvalid_q <= (fill_d != 2'h0);
			s_axi_arready <= (fill_d != 2'h2);
			if (pop) begin
				head_q <= (fill_q == 2'h2) ? tail_q : rd_word;
			end else if (push && fill_q == 2'h0) begin
				head_q <= rd_word;
			end
			if (push && ((fill_q == 2'h1 && !pop) || (fill_q == 2'h2))) begin
				tail_q <= rd_word;
			end
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = head_q[31:0];
	assign s_axi_rresp = head_q[33:32];
endmodule

// ==== sfd_consts.vh ====
// constants for the streaming fixed delay line and its register slave
`ifndef SFD_CONSTS_VH
`define SFD_CONSTS_VH
`define SFD_MAX_DELAY 16
`define SFD_DEF_DELAY 1
`define SFD_DEF_DATA_W 8
`define SFD_DEF_SYM_W 8
`define SFD_DEF_CHAN_W 1
`define SFD_DEF_MAX_CHAN 1
`define SFD_DEF_ERR_W 1
`define SFD_ADDR_W 4
`define SFD_OFF_CTRL 4'h0
`define SFD_OFF_BEATS 4'h4
`define SFD_OFF_CFG 4'h8
`define SFD_CTRL_CNT_EN 0
`define SFD_CTRL_CNT_CLR 1
`define SFD_CTRL_RST 1'b1
`define SFD_BEATS_RST 32'h0000_0000
`define SFD_RESP_OKAY 2'b00
`define SFD_RESP_SLVERR 2'b10
`define SFD_CFG_DELAY_LSB 0
`define SFD_CFG_PKT_BIT 8
`define SFD_CFG_CHAN_BIT 9
`define SFD_CFG_ERR_BIT 10
`endif

// ==== sfd_sink_model.sv ====
// stream sink model: takes every output beat and counts it
`timescale 1ns/1ps
module sfd_sink_model (
	input wire aclk,
	input wire aresetn,
	input wire beat_valid,
	output reg [15:0] beats_q
);
	// no ready exists, so a sink that cannot keep up would lose beats
	always @(posedge aclk) begin
		if (!aresetn) beats_q <= 16'h0000;
		else if (beat_valid) beats_q <= beats_q + 16'h0001;
	end
endmodule

// ==== sfd_chk_assertions.sv ====
// concurrent checks for the streaming delay line
`timescale 1ns/1ps
module sfd_chk #(parameter DELAY = 3) (
	input wire aclk,
	input wire aresetn,
	input wire in_valid,
	input wire [7:0] in_data,
	input wire [7:0] in_channel,
	input wire [3:0] in_error,
	input wire out_valid,
	input wire [7:0] out_data,
	input wire [7:0] out_channel,
	input wire [3:0] out_error,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	// cycles since release, saturating so the lag checks stay armed
	reg [4:0] up_q;
	always @(posedge aclk) up_q <= !aresetn ? 5'h00 : up_q + {4'h0, up_q != 5'h1f};
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	chk_valid_lag: assert property (up_q >= DELAY |-> out_valid == $past(in_valid, DELAY))
		else $error("valid lag wrong");
	chk_data_lag: assert property (up_q >= DELAY |-> out_data == $past(in_data, DELAY))
		else $error("data lag wrong");
	chk_side_lag: assert property (up_q >= DELAY |-> {out_channel, out_error} == $past({in_channel, in_error}, DELAY))
		else $error("sideband lag wrong");
	chk_reset_zero: assert property (disable iff (1'b0) !aresetn |=> !out_valid && out_data == 8'h00 && out_error == 4'h0)
		else $error("outputs not zero in reset");
	chk_quiet_start: assert property (up_q < DELAY |-> !out_valid && out_data == 8'h00)
		else $error("outputs not zero after release");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("rvalid dropped");
	chk_b_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready)
		else $error("write response late");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
		else $error("read response late");
	cover property (out_valid && up_q == DELAY);
	cover property (s_axi_rvalid && !s_axi_arready);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind sfd_delay_line sfd_chk #(.DELAY(DELAY)) u_chk (.*);

// ==== tb_sfd_delay_line.sv ====
// self-checking bench for the streaming delay line
`timescale 1ns/1ps
module tb_sfd_delay_line;
	localparam D = 3;
	reg aclk, aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	reg [31:0] s_axi_wdata, rs;
	reg [23:0] iv, e;
	wire in_valid, in_startofpacket, in_endofpacket, out_valid, out_startofpacket, out_endofpacket;
	wire [0:0] in_empty, out_empty;
	wire [7:0] in_data, in_channel, out_data, out_channel;
	wire [3:0] in_error, out_error;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [15:0] sink_beats;
	wire [23:0] ov = {out_valid, out_data, out_startofpacket, out_endofpacket, out_empty, out_channel, out_error};
	integer err_count = 0, checks = 0, vcount = 0;
	logic [23:0] sq[$];
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	assign {in_valid, in_data, in_startofpacket, in_endofpacket, in_empty, in_channel, in_error} = iv;
	sfd_delay_line #(.DELAY(D), .USE_PACKETS(1), .USE_CHANNEL(1), .CHAN_W(8), .MAX_CHAN(255), .USE_ERROR(1),
		.ERR_W(4)) uut (.*);
	sfd_sink_model snk (.aclk(aclk), .aresetn(aresetn), .beat_valid(out_valid), .beats_q(sink_beats));
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	function automatic [31:0] xs(input [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task cmp(input string n, input [33:0] x, input [33:0] s);
		checks++;
		if (x !== s) begin
			err_count++;
			$display("BAD %s exp %h got %h", n, x, s);
		end
	endtask
	task report_and_stop;
		if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wr(input [3:0] a, input [31:0] d, input [1:0] r);
		integer n;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				s_axi_bready <= 1'b0;
				n = 99;
			end
		end
		if (n == 50) begin
			err_count++;
			report_and_stop;
		end
		@(posedge aclk);
	endtask
	// k is how many read answers to drain; 0 leaves them queued
	task rd(input [3:0] a, input [33:0] x, input integer k);
		integer n, g;
		rq.push_back(x);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= k > 0;
		g = 1;
		for (n = 0; n < 50 && (g || k > 0); n++) begin
			@(posedge aclk);
			if (g && s_axi_arready) begin
				g = 0;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid && s_axi_rready) k--;
			if (k == 0) s_axi_rready <= 1'b0;
		end
		if (n == 50) begin
			err_count++;
			report_and_stop;
		end
		@(posedge aclk);
	endtask
	always @(posedge aclk) if (run) begin
		rs = xs(rs);
		iv <= rs[23:0];
		sq.push_back(rs[23:0]);
	end
	always @(negedge aclk) begin
		e = 24'h000000;
		if (sq.size() > D) e = sq.pop_front();
		vcount += e[23];
		cmp("stream", e, ov);
	end
	always @(posedge aclk) if (s_axi_bvalid && s_axi_bready) cmp("bresp", bq.pop_front(), s_axi_bresp);
	always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) cmp("read", rq.pop_front(), {s_axi_rdata, s_axi_rresp});
	initial begin
		{aresetn, run, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, iv} = 64'h0;
		s_axi_wstrb = 4'hf;
		rs = 32'h0001_4d9c;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		run <= 1'b1;
		rd(4'h8, {32'h0000_0703, 2'b00}, 0);
		rd(4'h0, {32'h0000_0001, 2'b00}, 0);
		#1 cmp("arready", 34'h0, s_axi_arready);
		rd(4'hc, {32'h0, 2'b10}, 3);
		wr(4'h8, 32'h0000_00ff, 2'b10);
		wr(4'hc, 32'h0000_0001, 2'b10);
		s_axi_wstrb <= 4'he;
		wr(4'h0, 32'h0000_0000, 2'b00);
		rd(4'h0, {32'h0000_0001, 2'b00}, 1);
		s_axi_wstrb <= 4'hf;
		wr(4'h0, 32'h0000_0000, 2'b00);
		wr(4'h0, 32'h0000_0002, 2'b00);
		rd(4'h4, {32'h0, 2'b00}, 1);
		rd(4'h0, {32'h0, 2'b00}, 1);
		repeat (200) @(posedge aclk);
		#1 cmp("sink beats", vcount, sink_beats);
		report_and_stop;
	end
endmodule
